// *** hdl/isf_pkg.sv ***
// Constants shared by the I/O sample payload framer.
// Function
// [RULE1] Payload opens with a sample-set count byte that is always one.
// [RULE2] Two-byte digital mask follows; bits 0 to 14 flag lines, bit 15 unused.
// [RULE3] One-byte analog mask follows; bits 0 to 3 flag analog channels.
// [RULE4] Two-byte digital state word follows the masks, one bit per line level.
// [RULE5] An all-zero digital mask drops the digital state word.
// [RULE6] Each set analog mask bit appends one two-byte analog value.
// [RULE7] Analog values go in ascending channel order, skipping clear bits.
// [RULE8] An all-zero analog mask appends no analog bytes.
// [RULE9] Payload layout is the same for every trigger source.
// [RULE10] Receivers wanting timer or change samples must run a framed mode.
// [RULE11] A sample command captures all enabled lines; no lines gives an error.
// [RULE12] Status byte is 00 on success, 01 when no line is enabled.
// [RULE13] Text mode returns hex fields separated by carriage returns.
// [RULE14] Framed requests get a response frame of type 0x88.
// [RULE15] Local requesters use frame type 0x08 or queued type 0x09.
// [RULE16] Response opens with 0x7E, a two-byte length, then frame type.
// [RULE17] Request identifier is echoed right after the frame type.
// [RULE18] Then two command characters, the status byte, then the payload.
// [RULE19] A host may ignore the trailing checksum.
// [RULE20] Digital mask bit set only for line codes 3, 4 or 5.
// [RULE21] Analog mask bit set only for line code 2.
// [RULE22] Analog values hold a right-aligned 10-bit result.
// [RULE23] Length counts frame type through last payload byte.
// [RULE24] Checksum is 0xFF minus the low byte of the counted bytes' sum.
package isf_pkg;
   // -------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------
   localparam int NUM_DIG = 15;
   localparam int NUM_ANA = 4;
   localparam int CFG_W = 3;
   localparam int ADC_W = 10;
   localparam int PAY_MAX = 14;
   localparam int BUF_W = 8;

   // -------------------------------------------------------------
   // Line configuration codes
   // -------------------------------------------------------------
   localparam logic [2:0] CFG_ANALOG = 3'h2;
   localparam logic [2:0] CFG_DIN = 3'h3;
   localparam logic [2:0] CFG_DOUT_LO = 3'h4;
   localparam logic [2:0] CFG_DOUT_HI = 3'h5;

   // -------------------------------------------------------------
   // Payload layout
   // -------------------------------------------------------------
   localparam logic [7:0] SET_COUNT = 8'h01;
   localparam logic [3:0] PL_COUNT = 4'h0;
   localparam logic [3:0] PL_DMASK_HI = 4'h1;
   localparam logic [3:0] PL_DMASK_LO = 4'h2;
   localparam logic [3:0] PL_AMASK = 4'h3;
   localparam logic [3:0] PL_DATA = 4'h4;
   localparam logic [3:0] PL_FULL = 4'hE;

   // -------------------------------------------------------------
   // Response frame bytes
   // -------------------------------------------------------------
   localparam logic [7:0] START_DELIM = 8'h7E;
   localparam logic [7:0] RESP_TYPE = 8'h88;
   localparam logic [7:0] CMD_HI = 8'h49;
   localparam logic [7:0] CMD_LO = 8'h53;
   localparam logic [7:0] STATUS_OK = 8'h00;
   localparam logic [7:0] STATUS_ERR = 8'h01;
   localparam logic [7:0] CSUM_BASE = 8'hFF;
   localparam logic [15:0] LEN_FIXED = 16'h0005;

   // -------------------------------------------------------------
   // Text mode characters
   // -------------------------------------------------------------
   localparam logic [7:0] ASCII_CR = 8'h0D;
   localparam logic [7:0] HEX_DIGIT = 8'h30;
   localparam logic [7:0] HEX_ALPHA = 8'h37;
   localparam logic [3:0] HEX_TEN = 4'hA;
   // Error reply, first character in the low byte.
   localparam logic [47:0] ERR_TEXT = 48'h0D524F525245;
   localparam logic [3:0] ERR_LAST = 4'h5;
endpackage

// *** hdl/isf_framer.sv ***
// I/O sample payload framer with its two-entry output buffer.

// -------------------------------------------------------------
// Two-entry output buffer
// -------------------------------------------------------------
module isf_buf2 #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [2];
   logic wr_ptr, rd_ptr, push, pop;
   logic [1:0] count, next_count;

   // Full at two words, empty at none.
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign next_count = count + {1'b0, push} - {1'b0, pop};

   // Storage is written only on a push.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mem[0] <= '0;
         mem[1] <= '0;
      end else if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and occupancy.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         wr_ptr <= wr_ptr ^ push;
         rd_ptr <= rd_ptr ^ pop;
         count <= next_count;
      end
   end
endmodule

// -------------------------------------------------------------
// Framer top
// -------------------------------------------------------------
module isf_framer (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Sample command.
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_framed,
   input wire logic [7:0] req_frame_id,
   // Line configuration, three bits per digital line.
   input wire logic [isf_pkg::NUM_DIG*isf_pkg::CFG_W-1:0] line_cfg,
   // Digital line pins.
   input wire logic [isf_pkg::NUM_DIG-1:0] digital_line,
   // Conversion results, ten bits per analog channel.
   input wire logic [isf_pkg::NUM_ANA*isf_pkg::ADC_W-1:0] adc_value,
   // Byte stream toward the serial port.
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_data,
   // Status.
   output logic busy
);
   import isf_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE, ST_START, ST_LEN_HI, ST_LEN_LO, ST_TYPE, ST_ID,
      ST_CMD_HI, ST_CMD_LO, ST_STATUS, ST_PAY, ST_CSUM,
      ST_TXT_HI, ST_TXT_LO, ST_TXT_CR, ST_TXT_ERR
   } isf_state_e;

   isf_state_e state, next_state;
   logic [NUM_DIG-1:0] dl_meta, dl_sync;
   logic [15:0] dmask, dstate, frame_len;
   logic [3:0] amask, bld_ptr, plen, idx, next_idx;
   logic [7:0] bld_pl [PAY_MAX];
   logic [7:0] pl [PAY_MAX];
   logic [PAY_MAX-1:0] bld_fe, fe;
   logic [7:0] fid, sum, gen_byte, cur;
   logic gen_valid, gen_fire, buf_in_ready, cap, pay_last, sum_en;

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      hex_char = (n < HEX_TEN) ? HEX_DIGIT + {4'h0, n}
                               : HEX_ALPHA + {4'h0, n};
   endfunction

   // -------------------------------------------------------------
   // Pin synchroniser and channel masks
   // -------------------------------------------------------------
   // Two flops ahead of any logic on the asynchronous line pins.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dl_meta <= '0;
         dl_sync <= '0;
      end else begin
         dl_meta <= digital_line;
         dl_sync <= dl_meta;
      end
   end

   // Mask bits from line codes; bit 15 of the digital mask stays zero.
   for (genvar g = 0; g < NUM_DIG; g++) begin : g_dig
      wire logic [2:0] c = line_cfg[g*CFG_W +: CFG_W];
      assign dmask[g] = (c == CFG_DIN) || (c == CFG_DOUT_LO) ||
                        (c == CFG_DOUT_HI); // RULE20 RULE2
   end
   assign dmask[15] = 1'b0; // RULE2
   for (genvar g = 0; g < NUM_ANA; g++) begin : g_ana
      assign amask[g] = (line_cfg[g*CFG_W +: CFG_W] == CFG_ANALOG); // RULE21
   end
   // State bits line up with mask bits; unsampled lines read low.
   assign dstate = {1'b0, dl_sync} & dmask; // RULE4

   // -------------------------------------------------------------
   // Payload assembly
   // -------------------------------------------------------------
   // One layout for any trigger source; field ends are marked for text.
   always_comb begin // RULE9
      bld_ptr = PL_DATA;
      bld_fe = '0;
      for (int i = 0; i < PAY_MAX; i++) begin
         bld_pl[i] = 8'h00;
      end
      bld_pl[PL_COUNT] = SET_COUNT; // RULE1
      bld_fe[PL_COUNT] = 1'b1;
      bld_pl[PL_DMASK_HI] = dmask[15:8]; // RULE2
      bld_pl[PL_DMASK_LO] = dmask[7:0];
      bld_fe[PL_DMASK_LO] = 1'b1;
      bld_pl[PL_AMASK] = {4'h0, amask}; // RULE3
      bld_fe[PL_AMASK] = 1'b1;
      if (dmask != 16'h0000) begin // RULE5
         bld_pl[bld_ptr] = dstate[15:8]; // RULE4
         bld_pl[bld_ptr + 4'h1] = dstate[7:0];
         bld_fe[bld_ptr + 4'h1] = 1'b1;
         bld_ptr = bld_ptr + 4'h2;
      end
      for (int ch = 0; ch < NUM_ANA; ch++) begin // RULE7
         if (amask[ch]) begin // RULE6 RULE8
            bld_pl[bld_ptr] = {6'h00, adc_value[ch*ADC_W+8 +: 2]}; // RULE22
            bld_pl[bld_ptr + 4'h1] = adc_value[ch*ADC_W +: 8];
            bld_fe[bld_ptr + 4'h1] = 1'b1;
            bld_ptr = bld_ptr + 4'h2;
         end
      end
      if (dmask == 16'h0000 && amask == 4'h0) begin // RULE11
         bld_ptr = 4'h0;
      end
   end

   assign req_ready = (state == ST_IDLE);
   assign busy = (state != ST_IDLE);
   assign cap = req_valid && req_ready;

   // Snapshot of all enabled lines, taken as the command is accepted.
   always_ff @(posedge clock or negedge reset_n) begin // RULE11
      if (!reset_n) begin
         for (int i = 0; i < PAY_MAX; i++) begin
            pl[i] <= 8'h00;
         end
         fe <= '0;
         plen <= 4'h0;
         fid <= 8'h00;
      end else if (cap) begin
         pl <= bld_pl;
         fe <= bld_fe;
         plen <= bld_ptr;
         fid <= req_frame_id;
      end
   end

   // -------------------------------------------------------------
   // Byte sequencer
   // -------------------------------------------------------------
   assign cur = pl[idx];
   assign pay_last = (idx == plen - 4'h1);
   assign frame_len = LEN_FIXED + {12'h000, plen}; // RULE23
   assign gen_valid = (state != ST_IDLE);
   assign gen_fire = gen_valid && buf_in_ready;
   assign sum_en = (state == ST_TYPE) || (state == ST_ID) ||
                   (state == ST_CMD_HI) || (state == ST_CMD_LO) ||
                   (state == ST_STATUS) || (state == ST_PAY);

   // Byte presented in each state.
   always_comb begin
      case (state)
         ST_START: gen_byte = START_DELIM; // RULE16
         ST_LEN_HI: gen_byte = frame_len[15:8]; // RULE16
         ST_LEN_LO: gen_byte = frame_len[7:0]; // RULE23
         ST_TYPE: gen_byte = RESP_TYPE; // RULE14
         ST_ID: gen_byte = fid; // RULE17
         ST_CMD_HI: gen_byte = CMD_HI; // RULE18
         ST_CMD_LO: gen_byte = CMD_LO; // RULE18
         ST_STATUS: gen_byte = (plen == 4'h0) ? STATUS_ERR : STATUS_OK; // RULE12
         ST_PAY: gen_byte = cur;
         ST_CSUM: gen_byte = CSUM_BASE - sum; // RULE24
         ST_TXT_HI: gen_byte = hex_char(cur[7:4]); // RULE13
         ST_TXT_LO: gen_byte = hex_char(cur[3:0]); // RULE13
         ST_TXT_CR: gen_byte = ASCII_CR; // RULE13
         ST_TXT_ERR: gen_byte = ERR_TEXT[idx*8 +: 8]; // RULE11
         default: gen_byte = 8'h00;
      endcase
   end

   // Next state and byte index; leaves ST_IDLE on an accepted command, otherwise moves only when the buffer takes a byte.
   always_comb begin
      next_state = state;
      next_idx = idx;
      case (state)
         ST_IDLE: begin
            next_idx = 4'h0;
            if (cap && req_framed) begin
               next_state = ST_START; // RULE14
            end else if (cap) begin
               next_state = (bld_ptr == 4'h0) ? ST_TXT_ERR : ST_TXT_HI;
            end
         end
         ST_START: next_state = ST_LEN_HI;
         ST_LEN_HI: next_state = ST_LEN_LO;
         ST_LEN_LO: next_state = ST_TYPE;
         ST_TYPE: next_state = ST_ID;
         ST_ID: next_state = ST_CMD_HI;
         ST_CMD_HI: next_state = ST_CMD_LO;
         ST_CMD_LO: next_state = ST_STATUS;
         ST_STATUS: next_state = (plen == 4'h0) ? ST_CSUM : ST_PAY; // RULE12
         ST_PAY: begin
            next_state = pay_last ? ST_CSUM : ST_PAY;
            next_idx = pay_last ? idx : idx + 4'h1;
         end
         ST_CSUM: next_state = ST_IDLE;
         ST_TXT_HI: next_state = ST_TXT_LO;
         ST_TXT_LO: begin
            next_state = fe[idx] ? ST_TXT_CR : ST_TXT_HI;
            next_idx = fe[idx] ? idx : idx + 4'h1;
         end
         ST_TXT_CR: begin
            next_state = pay_last ? ST_IDLE : ST_TXT_HI;
            next_idx = pay_last ? idx : idx + 4'h1;
         end
         ST_TXT_ERR: begin
            next_state = (idx == ERR_LAST) ? ST_IDLE : ST_TXT_ERR;
            next_idx = (idx == ERR_LAST) ? idx : idx + 4'h1;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Sequencer registers; the frame sum is zero outside the counted bytes.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         idx <= 4'h0;
         sum <= 8'h00;
      end else if (state == ST_IDLE || gen_fire) begin
         state <= next_state;
         idx <= next_idx;
         sum <= sum_en ? sum + gen_byte : 8'h00; // RULE24
      end
   end

   // -------------------------------------------------------------
   // Output buffer
   // -------------------------------------------------------------
   // A stalled receiver backs up into the sequencer; no byte is lost.
   isf_buf2 #(.WIDTH(BUF_W)) u_buf (
      .clock(clock),
      .reset_n(reset_n),
      .in_valid(gen_valid),
      .in_ready(buf_in_ready),
      .in_data(gen_byte),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_data)
   );

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   count_first_a: assert property (cap |=> pl[PL_COUNT] == SET_COUNT) // RULE1
      else $error("sample-set count is not one");
   mask_top_a: assert property (cap |=> !pl[PL_DMASK_HI][7]) // RULE2
      else $error("digital mask bit 15 set");
   amask_high_a: assert property (cap |=> pl[PL_AMASK][7:4] == 4'h0) // RULE3
      else $error("analog mask upper bits set");
   state_match_a: assert property (cap && dmask != 16'h0000 |=> // RULE4
      ({pl[PL_DATA], pl[PL_DATA + 4'h1]} & ~$past(dmask)) == 16'h0000)
      else $error("state bit outside digital mask");
   dig_omit_a: assert property (cap && dmask == 16'h0000 && // RULE5
      amask == 4'h1 |=> plen == 4'h6)
      else $error("digital word not omitted");
   ana_full_a: assert property (cap && dmask != 16'h0000 && // RULE6
      amask == 4'hF |=> plen == PL_FULL)
      else $error("analog values miscounted");
   ana_omit_a: assert property (cap && amask == 4'h0 && // RULE8
      dmask != 16'h0000 |=> plen == 4'h6)
      else $error("analog bytes without analog mask");
   status_val_a: assert property (state == ST_STATUS |-> // RULE12
      gen_byte == (({pl[PL_DMASK_HI], pl[PL_DMASK_LO], pl[PL_AMASK]} ==
      24'h000000) ? STATUS_ERR : STATUS_OK))
      else $error("status byte wrong");
   frame_head_a: assert property (cap && req_framed |=> // RULE16
      state == ST_START && gen_byte == START_DELIM)
      else $error("frame does not open with delimiter");
   id_echo_a: assert property (gen_fire && state == ST_TYPE |=> // RULE17
      state == ST_ID && gen_byte == fid)
      else $error("identifier not echoed after type");
   len_field_a: assert property (state == ST_LEN_LO |-> // RULE23
      gen_byte == 8'({4'h0, plen} + 8'h05))
      else $error("length byte wrong");
   csum_total_a: assert property (state == ST_CSUM |-> // RULE24
      8'(gen_byte + sum) == CSUM_BASE)
      else $error("checksum does not complete to 0xFF");

   framed_ok_c: cover property (gen_fire && state == ST_CSUM && plen != 4'h0);
   framed_err_c: cover property (gen_fire && state == ST_STATUS &&
      plen == 4'h0);
   text_end_c: cover property (gen_fire && state == ST_TXT_CR && pay_last);
   stall_c: cover property (out_valid && !out_ready && !buf_in_ready);
endmodule

// *** testbench/isf_host_model.sv ***
// Host receiver model that takes the framer's byte stream.
module isf_host_model (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Byte stream from the framer.
   input wire logic out_valid,
   output logic out_ready,
   input wire logic [7:0] out_data,
   // Pacing from the bench.
   input wire logic slow
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rx_q[$];
   int phase;

   // Every byte taken is kept, the checksum too, though a host may drop it.
   always @(posedge clock) begin
      if (reset_n && out_valid === 1'b1 && out_ready === 1'b1) begin
         rx_q.push_back(out_data);
      end
   end

   // Ready is low two cycles in three when pacing is slow.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         phase = 0;
         out_ready <= 1'b0;
      end else begin
         phase = (phase + 1) % 3;
         out_ready <= #10 (!slow || phase == 0);
      end
   end
endmodule

// *** testbench/isf_framer_test.sv ***
// Self-checking bench for the I/O sample payload framer.
module isf_framer_test;
   timeunit 1ns;
   timeprecision 1ns;
   import isf_pkg::*;
   typedef logic [7:0] isf_bq_t[$];
   typedef struct {
      logic framed;
      logic [7:0] id;
      logic [3:0] ana;
      logic [14:0] dig;
      logic [14:0] pins;
      logic [39:0] adc;
   } isf_row_s;

   logic clock = 1'b0;
   logic reset_n, req_valid, req_ready, req_framed, busy, slow;
   logic out_valid, out_ready;
   logic [7:0] req_frame_id, out_data;
   logic [44:0] line_cfg;
   logic [14:0] digital_line;
   logic [39:0] adc_value;
   int err_count = 0;
   int check_count = 0;
   int cycles = 0;
   isf_bq_t e;
   int n, takes;

   // Rows: framed, id, analog lines, digital lines, pin levels, results.
   isf_row_s rows[9] = '{
      '{1, 8'h53, 4'h3, 15'h0C0C, 15'h0408, {20'h0, 10'h124, 10'h3D0}},
      '{0, 8'h00, 4'h3, 15'h0C0C, 15'h0408, {20'h0, 10'h124, 10'h3D0}},
      '{1, 8'h53, 4'h1, 15'h0000, 15'h0000, {30'h0, 10'h3D0}},
      '{1, 8'hA5, 4'h0, 15'h7FF0, 15'h5555, 40'h0},
      '{1, 8'h11, 4'hF, 15'h7FF0, 15'h7FFF,
        {10'h3FF, 10'h000, 10'h2AA, 10'h155}},
      '{1, 8'h22, 4'h5, 15'h000A, 15'h7FFF,
        {10'h001, 10'h3FF, 10'h200, 10'h0FF}},
      '{1, 8'h33, 4'h0, 15'h0000, 15'h7FFF, 40'h0},
      '{0, 8'h00, 4'h0, 15'h0000, 15'h0000, 40'h0},
      '{0, 8'h00, 4'hA, 15'h4001, 15'h7FFF,
        {10'h3AB, 10'h000, 10'h0C4, 10'h000}}};

   always #50 clock = ~clock;

   isf_framer dut (
      .clock(clock), .reset_n(reset_n), .req_valid(req_valid),
      .req_ready(req_ready), .req_framed(req_framed),
      .req_frame_id(req_frame_id), .line_cfg(line_cfg),
      .digital_line(digital_line), .adc_value(adc_value),
      .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .busy(busy));

   isf_host_model host (
      .clock(clock), .reset_n(reset_n), .out_valid(out_valid),
      .out_ready(out_ready), .out_data(out_data), .slow(slow));

   // Cuts a hang short; the whole run needs a few hundred cycles.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 6000) begin
         err_count++;
         $display("Error timeout: run did not finish");
         results();
      end
   end

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(string what, logic [15:0] x, logic [15:0] g);
      check_count++;
      if (g !== x) begin
         err_count++;
         $display("Error %s: expected %h, seen %h", what, x, g);
      end
   endtask

   function automatic logic [7:0] hex_char(logic [3:0] v);
      return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
   endfunction

   // Line code for line k; unused lines get codes that must not count.
   function automatic logic [2:0] code_of(isf_row_s r, int k);
      if (k < 4 && r.ana[k]) return 3'h2;
      if (r.dig[k]) return 3'h3 + 3'(k % 3);
      case (k % 4)
         0: return 3'h0;
         1: return 3'h1;
         2: return (k >= 4) ? 3'h2 : 3'h6;
         default: return 3'h7;
      endcase
   endfunction

   // Expected reply bytes, worked out from the row's settings.
   function automatic isf_bq_t expect_bytes(isf_row_s r);
      isf_bq_t q;
      logic [15:0] fv[$];
      int fw[$];
      logic [7:0] sum;
      logic [15:0] len;
      logic err;
      err = (r.dig == 0) && (r.ana == 0);
      fv = '{16'h0001, {1'b0, r.dig}, {12'h000, r.ana}};
      fw = '{2, 4, 2};
      if (r.dig != 0) begin
         fv.push_back({1'b0, r.dig & r.pins});
         fw.push_back(4);
      end
      for (int ch = 0; ch < 4; ch++) begin
         if (r.ana[ch]) begin
            fv.push_back({6'h00, r.adc[10*ch +: 10]});
            fw.push_back(4);
         end
      end
      if (!r.framed) begin
         if (err) return '{8'h45, 8'h52, 8'h52, 8'h4F, 8'h52, 8'h0D};
         foreach (fv[i]) begin
            for (int d = fw[i] - 1; d >= 0; d--) begin
               q.push_back(hex_char(fv[i][4*d +: 4]));
            end
            q.push_back(8'h0D);
         end
         return q;
      end
      q = '{8'h88, r.id, 8'h49, 8'h53, {7'h00, err}};
      foreach (fv[i]) begin
         if (!err && fw[i] == 4) q.push_back(fv[i][15:8]);
         if (!err) q.push_back(fv[i][7:0]);
      end
      sum = 8'h00;
      foreach (q[i]) sum += q[i];
      len = 16'(q.size());
      q.push_back(8'hFF - sum);
      return {8'h7E, len[15:8], len[7:0], q};
   endfunction

   task automatic apply(isf_row_s r);
      for (int k = 0; k < 15; k++) line_cfg[3*k +: 3] = code_of(r, k);
      digital_line = r.pins;
      adc_value = r.adc;
      host.rx_q.delete();
      repeat (3) @(posedge clock);
      #10;
   endtask

   // Holds the request until ready is seen high before an edge.
   task automatic send(isf_row_s r, int count);
      int k;
      req_framed = r.framed;
      req_frame_id = r.id;
      req_valid = 1'b1;
      k = 0;
      while (count > 0 && k < 300) begin
         @(negedge clock);
         k++;
         if (req_ready === 1'b1) count--;
      end
      @(posedge clock);
      #10 req_valid = 1'b0;
   endtask

   task automatic drain_compare(isf_bq_t x, string name);
      int k;
      k = 0;
      while ((busy !== 1'b0 || out_valid !== 1'b0) && k < 300) begin
         @(posedge clock);
         #10 k++;
      end
      chk({name, " size"}, 16'(x.size()), 16'(host.rx_q.size()));
      foreach (x[i]) begin
         if (i < host.rx_q.size()) chk(name, x[i], host.rx_q[i]);
      end
      $display("Test %s done", name);
   endtask

   task automatic run_row(isf_row_s r, string name);
      apply(r);
      send(r, 1);
      drain_compare(expect_bytes(r), name);
   endtask

   task automatic reset_check(string name);
      chk({name, " busy"}, 16'h0000, {15'h0, busy});
      chk({name, " out_valid"}, 16'h0000, {15'h0, out_valid});
      chk({name, " req_ready"}, 16'h0001, {15'h0, req_ready});
      $display("Test %s done", name);
   endtask

   initial begin
      reset_n = 1'b0;
      req_valid = 1'b0;
      req_framed = 1'b0;
      req_frame_id = 8'h00;
      line_cfg = 45'h0;
      digital_line = 15'h0;
      adc_value = 40'h0;
      slow = 1'b0;
      repeat (12) @(posedge clock);
      reset_check("reset");
      #10 reset_n = 1'b1;
      @(posedge clock);
      #10;
      foreach (rows[i]) begin
         run_row(rows[i], $sformatf("row %0d", i));
      end
      // Receiver stalls so the two-entry buffer fills and waits.
      slow = 1'b1;
      run_row(rows[4], "stalled");
      slow = 1'b0;
      // Request held high across two frames: one take per frame only.
      apply(rows[2]);
      send(rows[2], 2);
      e = expect_bytes(rows[2]);
      drain_compare({e, e}, "back to back");
      // Reset in mid-frame, then a clean frame afterwards.
      apply(rows[0]);
      send(rows[0], 1);
      n = 0;
      while (host.rx_q.size() < 5 && n < 100) begin
         @(posedge clock);
         #10 n++;
      end
      reset_n = 1'b0;
      #10 reset_check("mid reset");
      repeat (12) @(posedge clock);
      #10 reset_n = 1'b1;
      run_row(rows[2], "after reset");
      results();
   end
endmodule
